//--- iuc_cal_bank.sv
`timescale 1ns/10ps
`default_nettype none
// Function
// - each accelerometer scale trim is signed 16-bit, zero is unity gain.
// - the x accelerometer trim scales the x accelerometer data.
// - y and z accelerometer trims act on their own axis the same way.
// - each gyro offset upper word is signed 16-bit, one step 0.02 deg/s.
// - each gyro offset has a 16-bit lower word, the less significant part.
// - the x gyro lower and upper words form one x gyro bias correction.
// - the y gyro lower and upper words form one y gyro bias correction.
// - the z gyro lower and upper words form one z gyro bias correction.
// - the accelerometer offset upper word is signed 16-bit, 0.8 mg a step.
// - x accelerometer lower and upper words form one x bias correction.
// - corrections follow factory compensation at the chain's sample rate.
module iuc_cal_bank (
    input wire logic CLK,
    input wire logic RST_N,
    input wire iuc_pkg::iuc_req_t REG_REQ,
    output iuc_pkg::iuc_rsp_t REG_RSP,
    input wire iuc_pkg::iuc_sample_t [iuc_pkg::IUC_NAXES-1:0] SENSOR_IN,
    output iuc_pkg::iuc_sample_t [iuc_pkg::IUC_NAXES-1:0] SENSOR_OUT
);
    iuc_pkg::iuc_top_state_t cur;
    iuc_pkg::iuc_top_state_t next_cur;
    logic page_hit;
    logic [6:0] waddr;
    logic [15:0] rd_word;
    logic signed [15:0] trim [iuc_pkg::IUC_NAXES];
    logic signed [31:0] bias [iuc_pkg::IUC_NAXES];

    // ==========================================================
    // register access
    // only the calibration page answers
    assign page_hit = REG_REQ.page == iuc_pkg::IUC_CAL_PAGE;
    assign waddr = {REG_REQ.addr[6:1], 1'b0};

    // read mux, unmapped reads as zero
    always_comb begin
        case (waddr)
            iuc_pkg::IUC_AX_SCALE: rd_word = cur.cal.accel_x_scale_trim;
            iuc_pkg::IUC_AY_SCALE: rd_word = cur.cal.accel_y_scale_trim;
            iuc_pkg::IUC_AZ_SCALE: rd_word = cur.cal.accel_z_scale_trim;
            iuc_pkg::IUC_GX_LO: rd_word = cur.cal.gyro_x_offset_lower;
            iuc_pkg::IUC_GX_HI: rd_word = cur.cal.gyro_x_offset_upper;
            iuc_pkg::IUC_GY_LO: rd_word = cur.cal.gyro_y_offset_lower;
            iuc_pkg::IUC_GY_HI: rd_word = cur.cal.gyro_y_offset_upper;
            iuc_pkg::IUC_GZ_LO: rd_word = cur.cal.gyro_z_offset_lower;
            iuc_pkg::IUC_GZ_HI: rd_word = cur.cal.gyro_z_offset_upper;
            iuc_pkg::IUC_AX_LO: rd_word = cur.cal.accel_x_offset_lower;
            iuc_pkg::IUC_AX_HI: rd_word = cur.cal.accel_x_offset_upper;
            default: rd_word = 16'h0000;
        endcase
    end

    // write decode and read answer
    always_comb begin
        next_cur = cur;
        next_cur.rsp.valid = REG_REQ.rd && page_hit;
        if (REG_REQ.rd && page_hit) begin
            next_cur.rsp.data = rd_word;
        end
        if (REG_REQ.wr && page_hit) begin
            case (waddr)
                iuc_pkg::IUC_AX_SCALE:
                    next_cur.cal.accel_x_scale_trim = REG_REQ.wdata;
                iuc_pkg::IUC_AY_SCALE:
                    next_cur.cal.accel_y_scale_trim = REG_REQ.wdata;
                iuc_pkg::IUC_AZ_SCALE:
                    next_cur.cal.accel_z_scale_trim = REG_REQ.wdata;
                iuc_pkg::IUC_GX_LO:
                    next_cur.cal.gyro_x_offset_lower = REG_REQ.wdata;
                iuc_pkg::IUC_GY_LO:
                    next_cur.cal.gyro_y_offset_lower = REG_REQ.wdata;
                iuc_pkg::IUC_GZ_LO:
                    next_cur.cal.gyro_z_offset_lower = REG_REQ.wdata;
                iuc_pkg::IUC_GX_HI:
                    next_cur.cal.gyro_x_offset_upper = REG_REQ.wdata;
                iuc_pkg::IUC_GY_HI:
                    next_cur.cal.gyro_y_offset_upper = REG_REQ.wdata;
                iuc_pkg::IUC_GZ_HI:
                    next_cur.cal.gyro_z_offset_upper = REG_REQ.wdata;
                iuc_pkg::IUC_AX_LO:
                    next_cur.cal.accel_x_offset_lower = REG_REQ.wdata;
                iuc_pkg::IUC_AX_HI:
                    next_cur.cal.accel_x_offset_upper = REG_REQ.wdata;
                default: ;
            endcase
        end
    end

    // state register, all zero after reset
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign REG_RSP = cur.rsp;

    // ==========================================================
    // per-axis correction terms
    // x accelerometer trim; gyros run at unity
    // y and z trims on their own axes
    assign trim[iuc_pkg::IUC_GX] = 16'sh0000;
    assign trim[iuc_pkg::IUC_GY] = 16'sh0000;
    assign trim[iuc_pkg::IUC_GZ] = 16'sh0000;
    assign trim[iuc_pkg::IUC_AX] = cur.cal.accel_x_scale_trim;
    assign trim[iuc_pkg::IUC_AY] = cur.cal.accel_y_scale_trim;
    assign trim[iuc_pkg::IUC_AZ] = cur.cal.accel_z_scale_trim;
    assign bias[iuc_pkg::IUC_GX] =
        {cur.cal.gyro_x_offset_upper, cur.cal.gyro_x_offset_lower};
    assign bias[iuc_pkg::IUC_GY] =
        {cur.cal.gyro_y_offset_upper, cur.cal.gyro_y_offset_lower};
    assign bias[iuc_pkg::IUC_GZ] =
        {cur.cal.gyro_z_offset_upper, cur.cal.gyro_z_offset_lower};
    assign bias[iuc_pkg::IUC_AX] =
        {cur.cal.accel_x_offset_upper, cur.cal.accel_x_offset_lower};
    assign bias[iuc_pkg::IUC_AY] = 32'sh00000000;
    assign bias[iuc_pkg::IUC_AZ] = 32'sh00000000;

    // ==========================================================
    // one corrector per axis after factory compensation
    // one result per incoming sample
    for (genvar i = 0; i < iuc_pkg::IUC_NAXES; i++) begin : g_axis
        iuc_axis_corr #(
            .SW(iuc_pkg::IUC_SW),
            .TW(iuc_pkg::IUC_DW)
        ) u_corr (
            .clk(CLK),
            .rst_n(RST_N),
            .smp_in(SENSOR_IN[i]),
            .scale_trim(trim[i]),
            .offset(bias[i]),
            .smp_out(SENSOR_OUT[i])
        );
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    sequence s_wr(logic [6:0] a);
        REG_REQ.wr && page_hit && waddr == a;
    endsequence
    sequence s_rd(logic [6:0] a);
        REG_REQ.rd && page_hit && !REG_REQ.wr && waddr == a;
    endsequence

    accel_readback_a: assert property (s_wr(iuc_pkg::IUC_AX_HI) ##1
        s_rd(iuc_pkg::IUC_AX_HI) |=> REG_RSP.valid
        && REG_RSP.data == $past(REG_REQ.wdata, 2))
        else $error("accel offset upper word did not read back");
    gx_join_a: assert property (s_wr(iuc_pkg::IUC_GX_HI)
        |=> bias[iuc_pkg::IUC_GX][31:16] == $past(REG_REQ.wdata))
        else $error("x gyro upper word not in bias bits 31:16");
    gy_join_a: assert property (s_wr(iuc_pkg::IUC_GY_LO)
        |=> bias[iuc_pkg::IUC_GY][15:0] == $past(REG_REQ.wdata))
        else $error("y gyro lower word not in bias bits 15:0");
    gz_join_a: assert property (s_wr(iuc_pkg::IUC_GZ_HI)
        |=> bias[iuc_pkg::IUC_GZ][31:16] == $past(REG_REQ.wdata))
        else $error("z gyro upper word not in bias bits 31:16");
    ax_join_a: assert property (s_wr(iuc_pkg::IUC_AX_LO)
        |=> bias[iuc_pkg::IUC_AX][15:0] == $past(REG_REQ.wdata))
        else $error("x accel lower word not in bias bits 15:0");
    ax_trim_a: assert property (s_wr(iuc_pkg::IUC_AX_SCALE)
        |=> trim[iuc_pkg::IUC_AX] == $past(REG_REQ.wdata))
        else $error("x accel trim not applied");
    az_trim_a: assert property (s_wr(iuc_pkg::IUC_AZ_SCALE)
        |=> trim[iuc_pkg::IUC_AZ] == $past(REG_REQ.wdata))
        else $error("z accel trim not applied");
    page_gate_a: assert property (REG_REQ.wr && !page_hit
        |=> $stable(cur.cal))
        else $error("write on another page changed a register");
    unmapped_a: assert property (REG_REQ.rd && page_hit
        && waddr == 7'h00 |=> REG_RSP.valid && REG_RSP.data == 16'h0000)
        else $error("unmapped read not zero");

    // ==========================================================
    // remaining word joins and trims
    gx_low_a: assert property (s_wr(iuc_pkg::IUC_GX_LO)
        |=> bias[iuc_pkg::IUC_GX][15:0] == $past(REG_REQ.wdata))
        else $error("x gyro lower word not in bias bits 15:0");
    gy_high_a: assert property (s_wr(iuc_pkg::IUC_GY_HI)
        |=> bias[iuc_pkg::IUC_GY][31:16] == $past(REG_REQ.wdata))
        else $error("y gyro upper word not in bias bits 31:16");
    gz_low_a: assert property (s_wr(iuc_pkg::IUC_GZ_LO)
        |=> bias[iuc_pkg::IUC_GZ][15:0] == $past(REG_REQ.wdata))
        else $error("z gyro lower word not in bias bits 15:0");
    ax_high_a: assert property (s_wr(iuc_pkg::IUC_AX_HI)
        |=> bias[iuc_pkg::IUC_AX][31:16] == $past(REG_REQ.wdata))
        else $error("x accel upper word not in bias bits 31:16");
    ay_trim_a: assert property (s_wr(iuc_pkg::IUC_AY_SCALE)
        |=> trim[iuc_pkg::IUC_AY] == $past(REG_REQ.wdata))
        else $error("y accel trim not applied");

    // answers only to reads on the calibration page; registers change only on writes there
    read_answer_a: assert property (REG_REQ.rd && page_hit
        |=> REG_RSP.valid)
        else $error("read on the page got no answer");
    read_refused_a: assert property (!(REG_REQ.rd && page_hit)
        |=> !REG_RSP.valid)
        else $error("answer without a read on the page");
    read_hold_a: assert property (!(REG_REQ.rd && page_hit)
        |=> $stable(REG_RSP.data))
        else $error("read data moved without a read");
    reg_hold_a: assert property (!(REG_REQ.wr && page_hit)
        |=> $stable(cur.cal))
        else $error("register changed without a write");

    // data path with neutral corrections
    gx_path_a: assert property (SENSOR_IN[iuc_pkg::IUC_GX].valid
        && bias[iuc_pkg::IUC_GX] == 32'sh00000000
        |=> SENSOR_OUT[iuc_pkg::IUC_GX].data
        == $past(SENSOR_IN[iuc_pkg::IUC_GX].data))
        else $error("x gyro sample altered with zero bias");
    ay_path_a: assert property (SENSOR_IN[iuc_pkg::IUC_AY].valid
        && trim[iuc_pkg::IUC_AY] == 16'sh0000
        |=> SENSOR_OUT[iuc_pkg::IUC_AY].data
        == $past(SENSOR_IN[iuc_pkg::IUC_AY].data))
        else $error("y accel sample altered with zero trim");
endmodule
`default_nettype wire

//--- iuc_pkg.sv
package iuc_pkg;
    // ==========================================================
    // widths and page
    localparam int IUC_AW = 7;
    localparam int IUC_DW = 16;
    localparam int IUC_SW = 32;
    localparam int IUC_SCALE_FRAC = 15;
    localparam logic [15:0] IUC_CAL_PAGE = 16'h0002;

    // ==========================================================
    // byte offsets inside the calibration page
    localparam logic [6:0] IUC_AX_SCALE = 7'h0a;
    localparam logic [6:0] IUC_AY_SCALE = 7'h0c;
    localparam logic [6:0] IUC_AZ_SCALE = 7'h0e;
    localparam logic [6:0] IUC_GX_LO = 7'h10;
    localparam logic [6:0] IUC_GX_HI = 7'h12;
    localparam logic [6:0] IUC_GY_LO = 7'h14;
    localparam logic [6:0] IUC_GY_HI = 7'h16;
    localparam logic [6:0] IUC_GZ_LO = 7'h18;
    localparam logic [6:0] IUC_GZ_HI = 7'h1a;
    localparam logic [6:0] IUC_AX_LO = 7'h1c;
    localparam logic [6:0] IUC_AX_HI = 7'h1e;
    localparam logic [15:0] IUC_REG_RESET = 16'h0000;

    // ==========================================================
    // axis slots on the sensor ports
    localparam int IUC_GX = 0;
    localparam int IUC_GY = 1;
    localparam int IUC_GZ = 2;
    localparam int IUC_AX = 3;
    localparam int IUC_AY = 4;
    localparam int IUC_AZ = 5;
    localparam int IUC_NAXES = 6;

    // ==========================================================
    // carriers
    typedef struct packed {
        logic valid;
        logic signed [31:0] data;
    } iuc_sample_t;

    typedef struct packed {
        logic [15:0] page;
        logic [6:0] addr;
        logic wr;
        logic rd;
        logic [15:0] wdata;
    } iuc_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } iuc_rsp_t;

    typedef struct packed {
        logic [15:0] accel_x_scale_trim;
        logic [15:0] accel_y_scale_trim;
        logic [15:0] accel_z_scale_trim;
        logic [15:0] gyro_x_offset_lower;
        logic [15:0] gyro_x_offset_upper;
        logic [15:0] gyro_y_offset_lower;
        logic [15:0] gyro_y_offset_upper;
        logic [15:0] gyro_z_offset_lower;
        logic [15:0] gyro_z_offset_upper;
        logic [15:0] accel_x_offset_lower;
        logic [15:0] accel_x_offset_upper;
    } iuc_cal_t;

    typedef struct packed {
        iuc_cal_t cal;
        iuc_rsp_t rsp;
    } iuc_top_state_t;
endpackage

//--- iuc_axis_corr.sv
`timescale 1ns/10ps
`default_nettype none
module iuc_axis_corr #(
    parameter int SW = 32,
    parameter int TW = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire iuc_pkg::iuc_sample_t smp_in,
    input wire logic signed [TW-1:0] scale_trim,
    input wire logic signed [SW-1:0] offset,
    output iuc_pkg::iuc_sample_t smp_out
);
    localparam int XW = SW + TW + 2;
    localparam logic signed [XW-1:0] SAT_HI =
        {{(XW-SW+1){1'b0}}, {(SW-1){1'b1}}};
    localparam logic signed [XW-1:0] SAT_LO =
        {{(XW-SW+1){1'b1}}, {(SW-1){1'b0}}};

    iuc_pkg::iuc_sample_t cur;
    iuc_pkg::iuc_sample_t next_cur;
    logic signed [SW+TW-1:0] prod;
    logic signed [XW-1:0] sum;

    // ==========================================================
    // gain then bias, saturated
    // gain term
    always_comb begin
        prod = smp_in.data * scale_trim;
        sum = XW'(smp_in.data) + XW'(prod >>> iuc_pkg::IUC_SCALE_FRAC)
            + XW'(offset);
        next_cur = cur;
        next_cur.valid = smp_in.valid;
        if (smp_in.valid) begin
            if (sum > SAT_HI) begin
                next_cur.data = SAT_HI[SW-1:0];
            end else if (sum < SAT_LO) begin
                next_cur.data = SAT_LO[SW-1:0];
            end else begin
                next_cur.data = sum[SW-1:0];
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign smp_out = cur;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    corr_latency_a: assert property (smp_in.valid |=> smp_out.valid)
        else $error("corrected sample not one cycle after input");
    unity_gain_a: assert property (smp_in.valid && scale_trim == '0
        && offset == '0 |=> smp_out.data == $past(smp_in.data))
        else $error("zero trim and zero offset altered sample");
    minus_one_a: assert property (smp_in.valid
        && scale_trim == {1'b1, {(TW-1){1'b0}}} && offset == '0
        |=> smp_out.data == '0)
        else $error("full negative trim did not null sample");
    sat_high_a: assert property (smp_in.valid && sum > SAT_HI
        |=> smp_out.data == SAT_HI[SW-1:0])
        else $error("positive overflow not clamped");
    hold_data_a: assert property (!smp_in.valid
        |=> $stable(smp_out.data))
        else $error("output moved without a sample");
endmodule
`default_nettype wire

//--- iuc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// host side of the paged register interface
module iuc_host_model (
    input wire logic clk,
    output iuc_pkg::iuc_req_t req,
    input wire iuc_pkg::iuc_rsp_t rsp
);
    // idle bus, no strobes
    initial begin
        req = '0;
    end

    // one access: strobe held over one edge, answer taken a cycle later
    task automatic access(input logic [15:0] pg, input logic [6:0] a,
            input logic w, input logic [15:0] d, output logic ok,
            output logic [15:0] q);
        @(negedge clk);
        req.page = pg;
        req.addr = a;
        req.wr = w;
        req.rd = !w;
        req.wdata = d;
        @(negedge clk);
        ok = rsp.valid;
        q = rsp.data;
        req.wr = 1'b0;
        req.rd = 1'b0;
        req.addr = ~a; // released lines do not keep old value
        req.wdata = ~d;
    endtask

    // write then read of one word on consecutive edges
    task automatic wr_rd(input logic [15:0] pg, input logic [6:0] a,
            input logic [15:0] d, output logic ok, output logic [15:0] q);
        @(negedge clk);
        req.page = pg;
        req.addr = a;
        req.wr = 1'b1;
        req.rd = 1'b0;
        req.wdata = d;
        @(negedge clk);
        req.wr = 1'b0;
        req.rd = 1'b1;
        req.wdata = ~d;
        @(negedge clk);
        ok = rsp.valid;
        q = rsp.data;
        req.rd = 1'b0;
        req.addr = ~a;
    endtask
endmodule
`default_nettype wire

//--- tb_iuc_cal_bank.sv
`timescale 1ns/10ps
`default_nettype none
module tb_iuc_cal_bank;
    logic CLK;
    logic RST_N;
    iuc_pkg::iuc_req_t REG_REQ;
    iuc_pkg::iuc_rsp_t REG_RSP;
    iuc_pkg::iuc_sample_t [iuc_pkg::IUC_NAXES-1:0] SENSOR_IN;
    iuc_pkg::iuc_sample_t [iuc_pkg::IUC_NAXES-1:0] SENSOR_OUT;
    int err_total = 0;
    int check_count = 0;
    int cyc = 0;
    logic [15:0] shadow [0:15];
    logic ok;
    logic [15:0] q;

    // ==========================================================
    // design and host
    iuc_cal_bank uut (.CLK(CLK), .RST_N(RST_N), .REG_REQ(REG_REQ),
        .REG_RSP(REG_RSP), .SENSOR_IN(SENSOR_IN), .SENSOR_OUT(SENSOR_OUT));
    iuc_host_model host (.clk(CLK), .req(REG_REQ), .rsp(REG_RSP));

    // clock and hang guard
    always #5 CLK = ~CLK;
    always @(posedge CLK) begin
        cyc++;
        if (cyc == 2000) begin
            err_total++;
            test_done();
        end
    end

    // ==========================================================
    // compares and verdict
    task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_smp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        if (err_total == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ==========================================================
    // expected corrected sample from shadow registers
    function automatic logic [31:0] corr(input logic [31:0] s, input int i);
        longint v;
        longint t;
        longint b;
        t = 0;
        b = 0;
        if (i >= 3) t = longint'($signed(shadow[i + 2]));
        if (i < 3) b = longint'($signed({shadow[9 + 2*i], shadow[8 + 2*i]}));
        if (i == 3) b = longint'($signed({shadow[15], shadow[14]}));
        v = longint'($signed(s));
        v = v + ((v * t) >>> 15) + b;
        if (v > 64'sh7fffffff) v = 64'sh7fffffff;
        if (v < -64'sh80000000) v = -64'sh80000000;
        return v[31:0];
    endfunction

    // ==========================================================
    // register and sample access
    task automatic rd_chk(input logic [15:0] pg, input logic [6:0] a,
            input logic vexp, input logic [15:0] dexp);
        host.access(pg, a, 1'b0, 16'h0000, ok, q);
        chk_reg({15'h0, ok}, {15'h0, vexp});
        if (vexp) chk_reg(q, dexp);
    endtask
    task automatic wr_reg(input int a, input logic [15:0] d);
        shadow[a/2] = d;
        host.access(16'h0002, 7'(a), 1'b1, d, ok, q);
    endtask
    task automatic read_all();
        for (int a = 10; a <= 30; a += 2) begin
            rd_chk(16'h0002, 7'(a), 1'b1, shadow[a/2]);
        end
    endtask
    // check last cycle's outputs, then present the next sample
    task automatic drive_chk(input logic v, input logic [31:0] s,
            input logic pv, input logic [31:0] p);
        @(negedge CLK);
        for (int i = 0; i < 6; i++) begin
            chk_reg({15'h0, SENSOR_OUT[i].valid}, {15'h0, pv});
            if (pv) chk_smp(SENSOR_OUT[i].data, corr(p + 32'(i), i));
            SENSOR_IN[i].valid = v;
            SENSOR_IN[i].data = v ? s + 32'(i) : ~SENSOR_IN[i].data;
        end
    endtask
    // three samples back to back, then idle
    task automatic run_stream();
        drive_chk(1'b1, 32'h00012345, 1'b0, 32'h0);
        drive_chk(1'b1, 32'h7ffffff0, 1'b1, 32'h00012345);
        drive_chk(1'b1, 32'h80000010, 1'b1, 32'h7ffffff0);
        drive_chk(1'b0, 32'h0, 1'b1, 32'h80000010);
        drive_chk(1'b0, 32'h0, 1'b0, 32'h0);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        CLK = 1'b0;
        RST_N = 1'b0;
        SENSOR_IN = '0;
        for (int k = 0; k < 16; k++) shadow[k] = 16'h0000;
        repeat (3) @(posedge CLK);
        @(negedge CLK);
        RST_N = 1'b1;
        read_all();
        run_stream();
        for (int a = 10; a <= 30; a += 2) wr_reg(a, 16'h8000 | 16'(a * 257));
        read_all();
        rd_chk(16'h0002, 7'h0b, 1'b1, shadow[5]);
        rd_chk(16'h0002, 7'h20, 1'b1, 16'h0000);
        host.access(16'h0003, 7'h0c, 1'b1, 16'h1234, ok, q);
        rd_chk(16'h0003, 7'h0c, 1'b0, 16'h0000);
        rd_chk(16'h0002, 7'h0c, 1'b1, shadow[6]);
        run_stream();
        shadow[15] = 16'h5a5a;
        host.wr_rd(16'h0002, 7'h1e, 16'h5a5a, ok, q);
        chk_reg({15'h0, ok}, 16'h0001);
        chk_reg(q, 16'h5a5a);
        rd_chk(16'h0002, 7'h00, 1'b1, 16'h0000);
        wr_reg(10, 16'h7fff);
        wr_reg(12, 16'h8000);
        wr_reg(18, 16'h7fff);
        wr_reg(30, 16'h0001);
        run_stream();
        @(negedge CLK);
        RST_N = 1'b0;
        for (int k = 0; k < 16; k++) shadow[k] = 16'h0000;
        repeat (2) @(negedge CLK);
        RST_N = 1'b1;
        read_all();
        run_stream();
        test_done();
    end
endmodule
`default_nettype wire
